// File: rtl/ilk_ctrl.sv
/*
 * Teach-in, lock decode, safety output and LED control of a solenoid
 * guard interlock, with a classic Wishbone register slave.
 * Assumes sys_rst_i is the power-on reset, a non-volatile store on the
 * same clock behind nv_*, and an actuator code valid with act_detect.
 */
// The Wishbone slave port and the address map were decided locally.
// Behaviour
// RL1: Power-up with actuator present starts teach: green off, red on, yellow 1 Hz.
// RL2: After ten seconds of teach, yellow flashes briefly at 3 Hz.
// RL3: No power-off within five minutes aborts teach; red flashes five times.
// RL4: After power returns, second detection of actuator activates and stores code.
// RL5: Single-teach variant keeps first pairing and refuses later teach.
// RL6: Repeat-teach variant allows new teach any number of times.
// RL7: New actuator code replaces old one; old actuator no longer accepted.
// RL8: After learning, safety outputs stay off ten minutes; the code applies this inhibit only in the repeat-teach variant.
// RL9: Green flashes until inhibit expired and new actuator detected.
// RL10: Power loss during inhibit restarts full inhibit at next power-up.
// RL11: No locking while handle sits between its two positions.
// RL12: Power-to-unlock: command high unlocks, low locks.
// RL13: Power-to-lock: command high locks, low releases.
// RL14: Standard outputs drop as soon as the interlock unlocks.
// RL15: Standard outputs return on relock while actuator stays inserted.
// RL16: Alternate outputs drop only when guard opens.
// RL17: Green supply, yellow operating condition, red error.
// RL18: Chain input missing: green 1 Hz, red off, yellow by guard state.
// RL19: All timings come from one free-running tick cleared at reset.
`timescale 1ns/1ps
`include "ilk_regs.svh"

module ilk_ctrl #(
   parameter int CODE_W      = 16,
   parameter int TICK_CYCLES = `ILK_CLK_HZ / `ILK_TICK_HZ,
   parameter int TEACH_MS    = `ILK_TEACH_MS,
   parameter int POWEROFF_MS = `ILK_POWEROFF_MS,
   parameter int INHIBIT_MS  = `ILK_INHIBIT_MS
) (
   input  wire logic                    clock_i,
   input  wire logic                    sys_rst_i,
   input  wire logic [7:0]              wb_adr_i,
   input  wire logic [31:0]             wb_dat_i,
   output logic      [31:0]             wb_dat_o,
   input  wire logic                    wb_we_i,
   input  wire logic [3:0]              wb_sel_i,
   input  wire logic                    wb_cyc_i,
   input  wire logic                    wb_stb_i,
   output logic                         wb_ack_o,
   input  wire ilk_pkg::ilk_pins_t      pins_i,
   input  wire logic [CODE_W-1:0]       act_code_i,
   input  wire ilk_pkg::ilk_nv_t        nv_i,
   input  wire logic [CODE_W-1:0]       nv_code_i,
   output ilk_pkg::ilk_nv_t             nv_o,
   output logic      [CODE_W-1:0]       nv_code_o,
   output logic                         nv_we_o,
   output logic                         lock_o,
   output logic                         safety_output_first_o,
   output logic                         safety_output_second_o,
   output ilk_pkg::ilk_led_t            led_o,
   output logic                         irq_o
);

   // ===============================================================
   // Pin synchronisers, three stages, second and third must agree
   localparam int NP = $bits(ilk_pkg::ilk_pins_t);
   logic [NP-1:0] s1;
   logic [NP-1:0] s2;
   logic [NP-1:0] s3;
   logic [NP-1:0] filt;
   logic [NP-1:0] next_filt;
   ilk_pkg::ilk_pins_t pin;

   for (genvar g = 0; g < NP; g++) begin : gsync
      always_comb begin
         next_filt[g] = (s2[g] == s3[g]) ? s3[g] : filt[g];
      end
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         s1   <= '0;
         s2   <= '0;
         s3   <= '0;
         filt <= '0;
      end else begin
         s1   <= pins_i;
         s2   <= s1;
         s3   <= s2;
         filt <= next_filt;
      end
   end
   assign pin = filt;

   // ===============================================================
   // Millisecond tick and flash phases
   logic [$clog2(TICK_CYCLES)-1:0] pre;
   logic [$clog2(TICK_CYCLES)-1:0] next_pre;
   logic [9:0]                     ph1;
   logic [9:0]                     next_ph1;
   logic [8:0]                     ph3;
   logic [8:0]                     next_ph3;
   logic                           tick;
   logic                           slow;
   logic                           fast;

   always_comb begin
      tick     = (pre == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1)); // RL19
      next_pre = tick ? '0 : pre + 1'b1;
      next_ph1 = ph1;
      next_ph3 = ph3;
      if (tick) begin
         next_ph1 = (ph1 == 10'(`ILK_SLOW_MS - 1)) ? '0 : ph1 + 1'b1;
         next_ph3 = (ph3 == 9'(`ILK_FAST_MS - 1)) ? '0 : ph3 + 1'b1;
      end
      slow = (ph1 < 10'(`ILK_SLOW_MS / 2));
      fast = (ph3 < 9'(`ILK_FAST_ON_MS));
   end
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         pre <= '0; // RL19
         ph1 <= '0;
         ph3 <= '0;
      end else begin
         pre <= next_pre;
         ph1 <= next_ph1;
         ph3 <= next_ph3;
      end
   end

   // ===============================================================
   // Control registers
   logic [4:0] ctrl;
   logic [3:0] irq_en;
   logic [3:0] irq_st;
   logic [3:0] ev;
   wire logic  indiv    = ctrl[`ILK_CTRL_INDIV];
   wire logic  single   = ctrl[`ILK_CTRL_SINGLE];
   wire logic  repeat_v = ctrl[`ILK_CTRL_REPEAT];
   wire logic  plock    = ctrl[`ILK_CTRL_PLOCK];
   wire logic  altout   = ctrl[`ILK_CTRL_ALTOUT];

   // ===============================================================
   // Teach and lock state
   ilk_pkg::ilk_state_t st;
   ilk_pkg::ilk_state_t next_st;
   logic [31:0]         tmr;
   logic [31:0]         next_tmr;
   logic [31:0]         itmr;
   logic [31:0]         next_itmr;
   logic [CODE_W-1:0]   code;
   logic [CODE_W-1:0]   next_code;
   logic [CODE_W-1:0]   pcode;
   logic [CODE_W-1:0]   next_pcode;
   ilk_pkg::ilk_nv_t    nv;
   ilk_pkg::ilk_nv_t    next_nv;
   logic                armed;
   logic                next_armed;
   logic                inh;
   logic                next_inh;
   logic                locked;
   logic                next_locked;
   logic                outs;
   logic                next_outs;
   logic                we;
   logic                next_we;
   logic                act_ok;
   logic                lock_req;
   logic                chain_ok;

   always_comb begin
      next_st     = st;
      next_tmr    = tick ? tmr + 1'b1 : tmr;
      next_itmr   = (tick && inh) ? itmr + 1'b1 : itmr;
      next_code   = code;
      next_pcode  = pcode;
      next_nv     = nv;
      next_armed  = armed;
      next_inh    = inh;
      next_we     = 1'b0;
      ev          = '0;
      chain_ok    = pin.chain_input_first & pin.chain_input_second;
      // Standard coding accepts any actuator
      act_ok      = pin.act_detect &
                    (!indiv || (nv.code_valid && !nv.pending &&
                                act_code_i == code)); // RL4 RL7
      lock_req    = plock ? pin.lock_cmd : !pin.lock_cmd; // RL12 RL13
      case (st)
         ilk_pkg::ILK_BOOT: begin
            // Store contents only valid after reset release
            next_nv    = nv_i;
            next_code  = nv_code_i;
            next_pcode = nv_code_i;
            next_armed = 1'b1;
            next_inh   = nv_i.inhibit; // RL10
            next_itmr  = '0; // RL10
            next_st    = ilk_pkg::ILK_RUN;
         end
         ilk_pkg::ILK_RUN: begin
            if (armed && pin.act_detect && indiv) begin
               next_armed = 1'b0;
               if (nv.pending && act_code_i == pcode) begin
                  next_code       = pcode; // RL4 RL7
                  next_nv.code_valid = 1'b1;
                  next_nv.pending = 1'b0;
                  next_nv.spent   = single; // RL5
                  next_nv.inhibit = repeat_v; // RL8
                  next_inh        = repeat_v; // RL8
                  next_itmr       = '0;
                  next_we         = 1'b1; // RL4
                  ev[`ILK_EV_COMMIT] = 1'b1;
               end else if (!(nv.code_valid && act_code_i == code) &&
                            !(nv.spent || (nv.code_valid && !repeat_v))) begin
                  next_pcode = act_code_i; // RL1 RL5 RL6
                  next_tmr   = '0;
                  next_st    = ilk_pkg::ILK_TEACH;
                  ev[`ILK_EV_TEACH] = 1'b1;
               end
            end else if (pin.act_detect) begin
               next_armed = 1'b0;
            end
            if (inh && itmr >= 32'(INHIBIT_MS) && act_ok) begin
               next_inh        = 1'b0; // RL9
               next_nv.inhibit = 1'b0;
               next_we         = 1'b1;
               ev[`ILK_EV_INH_DONE] = 1'b1;
            end
         end
         ilk_pkg::ILK_TEACH: begin
            if (tmr >= 32'(TEACH_MS)) begin
               // Pending code must survive the requested power cycle
               next_nv.pending = 1'b1; // RL2
               next_we         = 1'b1;
               next_tmr        = '0;
               next_st         = ilk_pkg::ILK_REQOFF;
            end
         end
         ilk_pkg::ILK_REQOFF: begin
            if (tmr >= 32'(POWEROFF_MS)) begin
               next_pcode      = code; // RL3
               next_nv.pending = 1'b0; // RL3
               next_we         = 1'b1;
               next_tmr        = '0;
               next_st         = ilk_pkg::ILK_ABORT;
               ev[`ILK_EV_ABORT] = 1'b1;
            end
         end
         ilk_pkg::ILK_ABORT: begin
            if (tmr >= 32'(`ILK_ABORT_FLASH * `ILK_SLOW_MS)) begin
               next_st = ilk_pkg::ILK_RUN; // RL3
            end
         end
         default: begin
            next_st = ilk_pkg::ILK_BOOT;
         end
      endcase
      // Locking needs closed guard; handle checked only when engaging
      next_locked = (st == ilk_pkg::ILK_RUN) && lock_req &&
                    pin.guard_closed && act_ok &&
                    (locked || pin.handle_ok); // RL11
      next_outs   = (st == ilk_pkg::ILK_RUN) && chain_ok && act_ok &&
                    !inh && // RL8
                    (altout ? pin.guard_closed // RL16
                            : next_locked); // RL14 RL15
   end
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         st     <= ilk_pkg::ILK_BOOT;
         tmr    <= '0; // RL19
         itmr   <= '0;
         code   <= '0;
         pcode  <= '0;
         nv     <= '0;
         armed  <= 1'b0;
         inh    <= 1'b0;
         locked <= 1'b0;
         outs   <= 1'b0;
         we     <= 1'b0;
      end else begin
         st     <= next_st;
         tmr    <= next_tmr;
         itmr   <= next_itmr;
         code   <= next_code;
         pcode  <= next_pcode;
         nv     <= next_nv;
         armed  <= next_armed;
         inh    <= next_inh;
         locked <= next_locked;
         outs   <= next_outs;
         we     <= next_we;
      end
   end

   assign nv_o      = nv;
   assign nv_code_o = pcode;
   assign nv_we_o   = we;
   assign lock_o    = locked;
   assign safety_output_first_o  = outs;
   assign safety_output_second_o = outs;

   // ===============================================================
   // LEDs
   ilk_pkg::ilk_led_t led;
   ilk_pkg::ilk_led_t next_led;

   always_comb begin
      next_led.green  = 1'b1; // RL17
      next_led.red    = 1'b0;
      next_led.yellow = locked ? 1'b1 :
                        (pin.guard_closed ? slow : 1'b0); // RL18
      if (!chain_ok || inh) begin
         next_led.green = slow; // RL9 RL18
      end
      case (st)
         ilk_pkg::ILK_TEACH: begin
            next_led = '{green: 1'b0, yellow: slow, red: 1'b1}; // RL1
         end
         ilk_pkg::ILK_REQOFF: begin
            next_led = '{green: 1'b0, yellow: fast, red: 1'b1}; // RL2
         end
         ilk_pkg::ILK_ABORT: begin
            next_led.red = slow; // RL3
         end
         default: begin
         end
      endcase
   end
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         led <= '0;
      end else begin
         led <= next_led;
      end
   end
   assign led_o = led;

   // ===============================================================
   // Wishbone slave, one wait state, unmapped reads return zero
   logic        ack;
   logic        next_ack;
   logic [31:0] dat;
   logic [31:0] next_dat;
   logic [4:0]  next_ctrl;
   logic [3:0]  next_irq_en;
   logic [3:0]  next_irq_st;
   logic [3:0]  clr;
   logic        wr;

   always_comb begin
      next_ack    = wb_cyc_i && wb_stb_i && !ack;
      wr          = next_ack && wb_we_i && wb_sel_i[0];
      next_dat    = '0;
      next_ctrl   = ctrl;
      next_irq_en = irq_en;
      clr         = '0;
      if (wb_adr_i == `ILK_CTRL_OFF) begin
         next_dat = {27'h0000000, ctrl};
         if (wr) begin
            next_ctrl = wb_dat_i[4:0];
         end
      end else if (wb_adr_i == `ILK_STAT_OFF) begin
         next_dat = {22'h000000, nv.spent, nv.pending, nv.code_valid,
                     inh, chain_ok, outs, locked, st};
      end else if (wb_adr_i == `ILK_IRQ_STAT_OFF) begin
         next_dat = {28'h0000000, irq_st};
      end else if (wb_adr_i == `ILK_IRQ_CLR_OFF) begin
         if (wr) begin
            clr = wb_dat_i[3:0];
         end
      end else if (wb_adr_i == `ILK_IRQ_EN_OFF) begin
         next_dat = {28'h0000000, irq_en};
         if (wr) begin
            next_irq_en = wb_dat_i[3:0];
         end
      end
      // A new event wins over a clear in the same cycle
      next_irq_st = (irq_st & ~clr) | ev;
      if (!next_ack) begin
         next_dat = dat;
      end
   end
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         ack    <= 1'b0;
         dat    <= '0;
         ctrl   <= `ILK_CTRL_RST;
         irq_en <= '0;
         irq_st <= '0;
      end else begin
         ack    <= next_ack;
         dat    <= next_dat;
         ctrl   <= next_ctrl;
         irq_en <= next_irq_en;
         irq_st <= next_irq_st;
      end
   end

   assign wb_ack_o = ack;
   assign wb_dat_o = dat;
   assign irq_o    = |(irq_st & irq_en);

endmodule

// File: common/ilk_regs.svh
/*
 * Register offsets, field positions, reset values and timing counts
 * of the guard interlock controller.
 * Assumes a 32-bit classic Wishbone bus with byte addresses.
 */
`ifndef ILK_REGS_SVH
`define ILK_REGS_SVH

// ==================================================================
// Register offsets
`define ILK_CTRL_OFF     8'h00
`define ILK_STAT_OFF     8'h04
`define ILK_IRQ_STAT_OFF 8'h08
`define ILK_IRQ_CLR_OFF  8'h0C
`define ILK_IRQ_EN_OFF   8'h10

// ==================================================================
// Control fields
`define ILK_CTRL_INDIV   0
`define ILK_CTRL_SINGLE  1
`define ILK_CTRL_REPEAT  2
`define ILK_CTRL_PLOCK   3
`define ILK_CTRL_ALTOUT  4
`define ILK_CTRL_RST     5'h05

// ==================================================================
// Interrupt events
`define ILK_EV_TEACH     0
`define ILK_EV_COMMIT    1
`define ILK_EV_ABORT     2
`define ILK_EV_INH_DONE  3

// ==================================================================
// Times in milliseconds, one tick is one millisecond
`define ILK_TICK_HZ      1000
`define ILK_CLK_HZ       50000000
`define ILK_TEACH_MS     10000
`define ILK_POWEROFF_MS  300000
`define ILK_INHIBIT_MS   600000
`define ILK_SLOW_MS      1000
`define ILK_FAST_MS      333
`define ILK_FAST_ON_MS   83
`define ILK_ABORT_FLASH  5

`endif

// File: common/ilk_pkg.sv
/*
 * Types of the guard interlock controller.
 * Assumes ilk_regs.svh for all numeric constants.
 */
package ilk_pkg;

   // ===============================================================
   // Control states
   typedef enum logic [2:0] {
      ILK_BOOT   = 3'b000,
      ILK_RUN    = 3'b001,
      ILK_TEACH  = 3'b010,
      ILK_REQOFF = 3'b011,
      ILK_ABORT  = 3'b100
   } ilk_state_t;

   // ===============================================================
   // Pin inputs, one bit each
   typedef struct packed {
      logic chain_input_first;
      logic chain_input_second;
      logic guard_closed;
      logic act_detect;
      logic handle_ok;
      logic lock_cmd;
   } ilk_pins_t;

   // ===============================================================
   // Non-volatile flags kept across power cycles
   typedef struct packed {
      logic code_valid;
      logic pending;
      logic inhibit;
      logic spent;
   } ilk_nv_t;

   // ===============================================================
   // Status LEDs
   typedef struct packed {
      logic green;
      logic yellow;
      logic red;
   } ilk_led_t;

endpackage

// File: test/ilk_ctrl_properties.sv
/* Port checker of the interlock controller.
   Assumes binding to ilk_ctrl and its timing parameters. */
`timescale 1ns/1ps
`include "ilk_regs.svh"
module ilk_ctrl_properties #(
   parameter int TICK_CYCLES = 4,
   parameter int INHIBIT_MS  = 10
) (
   input wire logic               clock_i,
   input wire logic               sys_rst_i,
   input wire logic [7:0]         wb_adr_i,
   input wire logic [31:0]        wb_dat_i,
   input wire logic               wb_we_i,
   input wire logic [3:0]         wb_sel_i,
   input wire logic               wb_cyc_i,
   input wire logic               wb_stb_i,
   input wire logic               wb_ack_o,
   input wire ilk_pkg::ilk_pins_t pins_i,
   input wire ilk_pkg::ilk_nv_t   nv_o,
   input wire logic               nv_we_o,
   input wire logic               lock_o,
   input wire logic               safety_output_first_o,
   input wire logic               safety_output_second_o
);
   // ==============================================================
   // Shadow of the variant bits and of the inhibit span
   logic [4:0] ctrl, next_ctrl;
   int         inh, next_inh;
   always_comb begin
      next_ctrl = ctrl;
      if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0]
          && wb_adr_i == `ILK_CTRL_OFF) begin
         next_ctrl = wb_dat_i[4:0];
      end
      next_inh = (inh > 0) ? inh - 1 : 0;
      // One tick short: the first tick may land just after the commit
      if (nv_we_o && nv_o.inhibit) begin
         next_inh = (INHIBIT_MS - 1) * TICK_CYCLES;
      end
   end
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         ctrl <= `ILK_CTRL_RST;
         inh  <= 0;
      end else begin
         ctrl <= next_ctrl;
         inh  <= next_inh;
      end
   end
   // ==============================================================
   // Properties
   default clocking @(posedge clock_i); endclocking
   default disable iff (sys_rst_i);
   ack_next_a:
      assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered in one cycle");
   ack_once_a:
      assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   unlock_cmd_a:
      assert property ((!ctrl[3] && pins_i.lock_cmd) [*8] |-> !lock_o)
      else $error("locked while unlock commanded");
   lock_cmd_a:
      assert property ((ctrl[3] && !pins_i.lock_cmd) [*8] |-> !lock_o)
      else $error("locked without lock command");
   std_unlock_a:
      assert property ((!lock_o && !ctrl[4]) [*2] |-> !safety_output_first_o)
      else $error("outputs on while unlocked");
   dual_out_a:
      assert property (safety_output_first_o == safety_output_second_o)
      else $error("safety outputs differ");
   open_drop_a:
      assert property (!pins_i.guard_closed [*8] |-> !safety_output_first_o)
      else $error("outputs on with guard open");
   handle_gap_a:
      assert property ((!pins_i.handle_ok && !lock_o) [*8] |=> !lock_o)
      else $error("locked with handle between positions");
   chain_gap_a:
      assert property ((!pins_i.chain_input_first
         || !pins_i.chain_input_second) [*8] |-> !safety_output_first_o)
      else $error("outputs on with chain input missing");
   inhibit_hold_a:
      assert property (inh != 0 |-> !safety_output_first_o)
      else $error("outputs on during enable inhibit");
endmodule
bind ilk_ctrl ilk_ctrl_properties #(
   .TICK_CYCLES(TICK_CYCLES), .INHIBIT_MS(INHIBIT_MS)) u_props (
   .clock_i(clock_i), .sys_rst_i(sys_rst_i), .wb_adr_i(wb_adr_i),
   .wb_dat_i(wb_dat_i), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
   .pins_i(pins_i), .nv_o(nv_o), .nv_we_o(nv_we_o), .lock_o(lock_o),
   .safety_output_first_o(safety_output_first_o),
   .safety_output_second_o(safety_output_second_o));

// File: test/ilk_nv_store.sv
/* Non-volatile store beside the interlock controller.
   Assumes one write strobe on the controller clock; no reset input,
   so a power cycle of the controller loses nothing. */
`timescale 1ns/1ps
module ilk_nv_store #(
   parameter int CODE_W = 16
) (
   input  wire logic              clock_i,
   input  wire logic              we_i,
   input  wire ilk_pkg::ilk_nv_t  nv_d_i,
   input  wire logic [CODE_W-1:0] code_d_i,
   output ilk_pkg::ilk_nv_t       nv_q_o,
   output logic      [CODE_W-1:0] code_q_o
);
   // ==============================================================
   // Blank at delivery
   ilk_pkg::ilk_nv_t  nv_m   = '0;
   logic [CODE_W-1:0] code_m = '0;
   always @(posedge clock_i) begin
      if (we_i) begin
         nv_m   <= nv_d_i;
         code_m <= code_d_i;
      end
   end
   assign nv_q_o   = nv_m;
   assign code_q_o = code_m;
endmodule

// File: test/tb_ilk_ctrl.sv
/* Testbench of the interlock controller with its store model.
   Assumes shortened counts: one tick is four clocks. */
`timescale 1ns/1ps
`include "ilk_regs.svh"
module tb_ilk_ctrl;
   // ==============================================================
   // Stimulus and observed signals
   localparam int TK = 4;
   localparam logic [7:0] VT [5] = '{8'h04, 8'h03, 8'h40, 8'h47, 8'hC1};
   logic               clock_i    = 1'b0;
   logic               sys_rst_i  = 1'b1;
   logic [7:0]         wb_adr_i   = 8'h00;
   logic [31:0]        wb_dat_i   = 32'h0;
   logic               wb_we_i    = 1'b0;
   logic               wb_cyc_i   = 1'b0;
   logic               wb_stb_i   = 1'b0;
   ilk_pkg::ilk_pins_t pins_i     = '0;
   logic [15:0]        act_code_i = 16'h0;
   logic [31:0]        wb_dat_o, rd;
   logic [15:0]        nv_code_i, nv_code_o;
   ilk_pkg::ilk_nv_t   nv_i, nv_o;
   ilk_pkg::ilk_led_t  led_o;
   logic               wb_ack_o, nv_we_o, lock_o, so1, so2, irq_o;
   int                 err_total = 0;
   int                 checks    = 0;
   ilk_ctrl #(.TICK_CYCLES(TK), .TEACH_MS(5), .POWEROFF_MS(10),
      .INHIBIT_MS(10)) DUT (
      .clock_i(clock_i), .sys_rst_i(sys_rst_i), .wb_adr_i(wb_adr_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i),
      .wb_sel_i(4'hF), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_ack_o(wb_ack_o), .pins_i(pins_i), .act_code_i(act_code_i),
      .nv_i(nv_i), .nv_code_i(nv_code_i), .nv_o(nv_o),
      .nv_code_o(nv_code_o), .nv_we_o(nv_we_o), .lock_o(lock_o),
      .safety_output_first_o(so1), .safety_output_second_o(so2),
      .led_o(led_o), .irq_o(irq_o));
   ilk_nv_store #(.CODE_W(16)) u_store (.clock_i(clock_i),
      .we_i(nv_we_o), .nv_d_i(nv_o), .code_d_i(nv_code_o),
      .nv_q_o(nv_i), .code_q_o(nv_code_i));
   initial begin
      forever #10 clock_i = ~clock_i;
   end
   // ==============================================================
   // Tasks
   task automatic check(input string what, input logic [31:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wb(input logic we, input logic [7:0] adr,
                     input logic [31:0] dat);
      int n;
      n = 0;
      @(posedge clock_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_dat_i <= dat;
      do begin
         @(posedge clock_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      check("bus ack", {31'h0, wb_ack_o}, 32'h1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clock_i);
   endtask
   // Power cycle: the store model keeps its contents
   task automatic pw();
      sys_rst_i <= 1'b1;
      pins_i    <= '0;
      idle(5);
      sys_rst_i <= 1'b0;
      wb(1'b1, `ILK_IRQ_EN_OFF, 32'hF);
      wb(1'b0, `ILK_CTRL_OFF, 32'h0);
      check("control reset", rd, {27'h0, `ILK_CTRL_RST});
   endtask
   task automatic state(input logic [2:0] exp);
      wb(1'b0, `ILK_STAT_OFF, 32'h0);
      check("state", {29'h0, rd[2:0]}, {29'h0, exp});
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      idle(20000);
      err_total++;
      tally_and_finish();
   end
   // ==============================================================
   // Tests
   initial begin
      int n;
      pw();
      wb(1'b1, `ILK_CTRL_OFF, 32'h0);
      wb(1'b0, 8'h20, 32'h0);
      check("unmapped read", rd, 32'h0);
      wb(1'b0, `ILK_IRQ_CLR_OFF, 32'h0);
      check("clear read", rd, 32'h0);
      act_code_i <= 16'h1234;
      pins_i     <= 6'h3E;
      for (int i = 0; i < 5; i++) begin
         wb(1'b1, `ILK_CTRL_OFF, {27'h0, VT[i][7:3]});
         pins_i.lock_cmd <= VT[i][2];
         idle(10);
         check("lock", {31'h0, lock_o}, {31'h0, VT[i][1]});
         check("outputs", {30'h0, so1, so2}, {30'h0, {2{VT[i][0]}}});
      end
      pins_i.guard_closed <= 1'b0;
      idle(10);
      check("outputs open", {31'h0, so1}, 32'h0);
      pins_i <= 6'h3D;
      idle(10);
      check("lock handle", {31'h0, lock_o}, 32'h0);
      pins_i <= 6'h1F;
      idle(10);
      check("chain outputs", {31'h0, so1}, 32'h0);
      check("chain leds", {30'h0, led_o.yellow, led_o.red}, 32'h2);
      n = 0;
      repeat (TK * 1000) begin
         @(posedge clock_i);
         n += int'(led_o.green === 1'b1);
      end
      check("green on cycles", n, TK * 500);
      $display("test lock decode finished");
      pw();
      act_code_i <= 16'hA5A5;
      pins_i     <= 6'h3E;
      idle(8);
      check("teach leds", {30'h0, led_o.green, led_o.red}, 32'h1);
      state(3'h2);
      check("irq", {31'h0, irq_o}, 32'h1);
      wb(1'b1, `ILK_IRQ_EN_OFF, 32'h0);
      idle(1);
      check("irq masked", {31'h0, irq_o}, 32'h0);
      wb(1'b1, `ILK_IRQ_CLR_OFF, 32'hF);
      wb(1'b0, `ILK_IRQ_STAT_OFF, 32'h0);
      check("irq status", rd, 32'h0);
      idle(20);
      check("store pending", {29'h0, nv_i[3:1]}, 32'h2);
      state(3'h3);
      pw();
      pins_i <= 6'h3E;
      idle(12);
      check("store commit", {29'h0, nv_i[3:1]}, 32'h5);
      check("store code", {16'h0, nv_code_i}, 32'hA5A5);
      check("outputs inhibit", {31'h0, so1}, 32'h0);
      pw();
      pins_i <= 6'h3E;
      idle(24);
      check("outputs restart", {31'h0, so1}, 32'h0);
      idle(40);
      check("outputs after", {31'h0, so1}, 32'h1);
      check("inhibit cleared", {31'h0, nv_i.inhibit}, 32'h0);
      check("leds run", {30'h0, led_o.green, led_o.red}, 32'h2);
      $display("test teach finished");
      pw();
      act_code_i <= 16'h5A5A;
      pins_i     <= 6'h3E;
      idle(12);
      state(3'h2);
      idle(70);
      state(3'h4);
      check("store abort", {29'h0, nv_i[3:1]}, 32'h4);
      check("code kept", {16'h0, nv_code_i}, 32'hA5A5);
      wb(1'b0, `ILK_IRQ_STAT_OFF, 32'h0);
      check("abort event", {31'h0, rd[`ILK_EV_ABORT]}, 32'h1);
      $display("test abort finished");
      pw();
      wb(1'b1, `ILK_CTRL_OFF, 32'h3);
      pins_i <= 6'h3E;
      idle(12);
      state(3'h1);
      $display("test single teach finished");
      tally_and_finish();
   end
endmodule
